/* File: logic/cocc_defines.svh */
`ifndef COCC_DEFINES_SVH
`define COCC_DEFINES_SVH

// register indices; byte address is four times the index
`define COCC_IDX_DIV       8'h26
`define COCC_IDX_CTL       8'h27
`define COCC_ADDR_DIV      12'h098
`define COCC_ADDR_CTL      12'h09c

`define COCC_DIV_RESET     8'h02
`define COCC_SRC_RESET     2'h0
`define COCC_FMT_RESET     2'h1
`define COCC_SETA_RESET    2'h2
`define COCC_SETB_RESET    2'h0

// field positions inside the control register
`define COCC_SRC_HI        7
`define COCC_SRC_LO        6
`define COCC_FMT_HI        5
`define COCC_FMT_LO        4
`define COCC_SETA_HI       3
`define COCC_SETA_LO       2
`define COCC_SETB_HI       1
`define COCC_SETB_LO       0

`define COCC_ADDR_W        12
`define COCC_NUM_SRC       4
`define COCC_SYNC_DEPTH    3

`endif

/* File: logic/cocc_pkg.sv */
package cocc_pkg;

	typedef enum logic [1:0] {
		COCC_SRC_SYNTH_ONE = 2'h0,
		COCC_SRC_SYNTH_TWO = 2'h1,
		COCC_SRC_REF_PRI   = 2'h2,
		COCC_SRC_REF_SEC   = 2'h3
	} cocc_src_t;

	typedef enum logic [1:0] {
		COCC_FMT_OFF  = 2'h0,
		COCC_FMT_DIFF = 2'h1,
		COCC_FMT_HCSL = 2'h2,
		COCC_FMT_CMOS = 2'h3
	} cocc_fmt_t;

	typedef enum logic [1:0] {
		COCC_SET_TRISTATE = 2'h0,
		COCC_SET_LOW      = 2'h1,
		COCC_SET_INVERT   = 2'h2,
		COCC_SET_TRUE     = 2'h3
	} cocc_set_t;

endpackage

/* File: logic/cocc_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module cocc_divider (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       srcLevel,
	input  wire logic       srcRise,
	input  wire logic [7:0] divValue,
	input  wire logic       bypass,
	output logic            divOut
);
	import cocc_pkg::*;

	logic [7:0] count;
	logic [7:0] next_count;
	logic       phase;
	logic       next_phase;

	// ratio is divValue+1 source periods; high for the first half
	always_comb begin
		next_count = count;
		next_phase = phase;
		if (srcRise) begin
			if (count >= divValue) begin
				next_count = 8'h00;
			end else begin
				next_count = count + 8'h01;
			end
			next_phase = (next_count <= (divValue >> 1));
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			count <= 8'h00;
			phase <= 1'b0;
		end else begin
			count <= next_count;
			phase <= next_phase;
		end
	end

	// ratio one and the reference path both pass the source level through
	always_comb begin
		if (bypass || divValue == 8'h00) begin
			divOut = srcLevel;
		end else begin
			divOut = phase;
		end
	end

endmodule

`default_nettype wire

/* File: logic/cocc_pin_driver.sv */
`timescale 1ns/1ps
`default_nettype none

module cocc_pin_driver (
	input  wire logic            clock,
	input  wire logic            rst,
	input  wire logic            clkLevel,
	input  wire cocc_pkg::cocc_fmt_t format,
	input  wire cocc_pkg::cocc_set_t setting,
	output logic                 pinOut,
	output logic                 pinOe
);
	import cocc_pkg::*;

	logic next_pinOut;
	logic next_pinOe;

	always_comb begin
		next_pinOut = 1'b0;
		next_pinOe  = 1'b0;
		unique case (format)
			COCC_FMT_OFF: begin
				next_pinOut = 1'b0;
				next_pinOe  = 1'b0;
			end
			COCC_FMT_DIFF, COCC_FMT_HCSL: begin
				// electrical settings have no logic effect here
				next_pinOut = clkLevel;
				next_pinOe  = 1'b1;
			end
			COCC_FMT_CMOS: begin
				unique case (setting)
					COCC_SET_TRISTATE: begin
						next_pinOut = 1'b0;
						next_pinOe  = 1'b0;
					end
					COCC_SET_LOW: begin
						next_pinOut = 1'b0;
						next_pinOe  = 1'b1;
					end
					COCC_SET_INVERT: begin
						next_pinOut = ~clkLevel;
						next_pinOe  = 1'b1;
					end
					COCC_SET_TRUE: begin
						next_pinOut = clkLevel;
						next_pinOe  = 1'b1;
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pinOut <= 1'b0;
			pinOe  <= 1'b0;
		end else begin
			pinOut <= next_pinOut;
			pinOe  <= next_pinOe;
		end
	end

endmodule

`default_nettype wire

/* File: logic/cocc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cocc_defines.svh"

// Overview of operation
// - divide by field value plus one
// - divider acts only on synthesizer sources
// - divider field resets to two, ratio three
// - source select picks synth or reference, resets 0
// - reference sources bypass the divider
// - format select off/diff/HCSL/LVCMOS, resets 1
// - setting A drives positive pin, resets 2
// - setting B drives negative pin, resets 0
module cocc_channel (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        synthOneClk,
	input  wire logic        synthTwoClk,
	input  wire logic        refPriClk,
	input  wire logic        refSecClk,
	output logic             outP,
	output logic             outPOe,
	output logic             outN,
	output logic             outNOe,
	output cocc_pkg::cocc_fmt_t driverFormat
);
	import cocc_pkg::*;

	logic [7:0]  divider;
	logic [7:0]  next_divider;
	cocc_src_t   channelSourceSelect;
	cocc_src_t   next_channelSourceSelect;
	cocc_fmt_t   next_driverFormat;
	cocc_set_t   driverSettingA;
	cocc_set_t   next_driverSettingA;
	cocc_set_t   driverSettingB;
	cocc_set_t   next_driverSettingB;
	logic        next_pready;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        writeHit;
	logic        hitDiv;
	logic        hitCtl;
	logic [7:0]  ctlValue;

	// ---------------------------------------------------------------
	// APB slave: one wait-free access, answer registered at setup
	// ---------------------------------------------------------------
	always_comb begin
		hitDiv   = (paddr == `COCC_ADDR_DIV);
		hitCtl   = (paddr == `COCC_ADDR_CTL);
		writeHit = psel && penable && pready && pwrite;
		ctlValue = {channelSourceSelect, driverFormat,
			driverSettingA, driverSettingB};
	end

	always_comb begin
		next_pready  = psel && !penable;
		next_prdata  = prdata;
		next_pslverr = pslverr;
		if (psel && !penable) begin
			next_pslverr = !(hitDiv || hitCtl);
			if (!pwrite && hitDiv) begin
				next_prdata = {24'h000000, divider};
			end else if (!pwrite && hitCtl) begin
				next_prdata = {24'h000000, ctlValue};
			end else begin
				next_prdata = 32'h00000000;
			end
		end
	end

	always_comb begin
		next_divider             = divider;
		next_channelSourceSelect = channelSourceSelect;
		next_driverFormat        = driverFormat;
		next_driverSettingA      = driverSettingA;
		next_driverSettingB      = driverSettingB;
		if (writeHit && hitDiv) begin
			next_divider = pwdata[7:0];
		end
		if (writeHit && hitCtl) begin
			next_channelSourceSelect = cocc_src_t'(
				pwdata[`COCC_SRC_HI:`COCC_SRC_LO]);
			next_driverFormat = cocc_fmt_t'(
				pwdata[`COCC_FMT_HI:`COCC_FMT_LO]);
			next_driverSettingA = cocc_set_t'(
				pwdata[`COCC_SETA_HI:`COCC_SETA_LO]);
			next_driverSettingB = cocc_set_t'(
				pwdata[`COCC_SETB_HI:`COCC_SETB_LO]);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= next_pready;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			divider             <= `COCC_DIV_RESET;
			channelSourceSelect <= cocc_src_t'(`COCC_SRC_RESET);
			driverFormat        <= cocc_fmt_t'(`COCC_FMT_RESET);
			driverSettingA      <= cocc_set_t'(`COCC_SETA_RESET);
			driverSettingB      <= cocc_set_t'(`COCC_SETB_RESET);
		end else begin
			divider             <= next_divider;
			channelSourceSelect <= next_channelSourceSelect;
			driverFormat        <= next_driverFormat;
			driverSettingA      <= next_driverSettingA;
			driverSettingB      <= next_driverSettingB;
		end
	end

	// ---------------------------------------------------------------
	// source clocks arrive from other domains: three-stage sampling,
	// a change counts once stages two and three agree
	// ---------------------------------------------------------------
	logic [`COCC_NUM_SRC-1:0] srcRaw;
	logic [`COCC_NUM_SRC-1:0] syncOne;
	logic [`COCC_NUM_SRC-1:0] syncTwo;
	logic [`COCC_NUM_SRC-1:0] syncThree;
	logic [`COCC_NUM_SRC-1:0] srcLevel;
	logic [`COCC_NUM_SRC-1:0] next_srcLevel;
	logic [`COCC_NUM_SRC-1:0] next_syncOne;
	logic [`COCC_NUM_SRC-1:0] next_syncTwo;
	logic [`COCC_NUM_SRC-1:0] next_syncThree;

	always_comb begin
		srcRaw         = {refSecClk, refPriClk, synthTwoClk, synthOneClk};
		next_syncOne   = srcRaw;
		next_syncTwo   = syncOne;
		next_syncThree = syncTwo;
	end

	genvar g;
	generate
		for (g = 0; g < `COCC_NUM_SRC; g = g + 1) begin : gSync
			always_comb begin
				if (syncTwo[g] == syncThree[g]) begin
					next_srcLevel[g] = syncThree[g];
				end else begin
					next_srcLevel[g] = srcLevel[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			syncOne   <= 4'h0;
			syncTwo   <= 4'h0;
			syncThree <= 4'h0;
			srcLevel  <= 4'h0;
		end else begin
			syncOne   <= next_syncOne;
			syncTwo   <= next_syncTwo;
			syncThree <= next_syncThree;
			srcLevel  <= next_srcLevel;
		end
	end

	// ---------------------------------------------------------------
	// source mux, edge detect and divider
	// ---------------------------------------------------------------
	logic selLevel;
	logic selPrev;
	logic next_selPrev;
	logic selRise;
	logic isReference;
	logic chanClk;

	always_comb begin
		selLevel    = srcLevel[channelSourceSelect];
		selRise     = selLevel && !selPrev;
		next_selPrev = selLevel;
		isReference = (channelSourceSelect == COCC_SRC_REF_PRI) ||
			(channelSourceSelect == COCC_SRC_REF_SEC);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			selPrev <= 1'b0;
		end else begin
			selPrev <= next_selPrev;
		end
	end

	cocc_divider uDivider (
		.clock    (clock),
		.rst      (rst),
		.srcLevel (selLevel),
		.srcRise  (selRise),
		.divValue (divider),
		.bypass   (isReference),
		.divOut   (chanClk)
	);

	// negative pin of a differential pair carries the complement
	cocc_pin_driver uDrvP (
		.clock    (clock),
		.rst      (rst),
		.clkLevel (chanClk),
		.format   (driverFormat),
		.setting  (driverSettingA),
		.pinOut   (outP),
		.pinOe    (outPOe)
	);

	logic chanClkN;
	always_comb begin
		if (driverFormat == COCC_FMT_CMOS) begin
			chanClkN = chanClk;
		end else begin
			chanClkN = ~chanClk;
		end
	end

	cocc_pin_driver uDrvN (
		.clock    (clock),
		.rst      (rst),
		.clkLevel (chanClkN),
		.format   (driverFormat),
		.setting  (driverSettingB),
		.pinOut   (outN),
		.pinOe    (outNOe)
	);

endmodule

`default_nettype wire

/* File: bench/cocc_channel_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cocc_defines.svh"
module cocc_channel_properties (
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic                pready,
	input  wire logic [31:0]         prdata,
	input  wire logic                refPriClk,
	input  wire logic                outP,
	input  wire logic                outPOe,
	input  wire logic                outN,
	input  wire logic                outNOe,
	input  wire cocc_pkg::cocc_fmt_t driverFormat
);
	import cocc_pkg::*;
	logic [7:0] shDiv;
	logic [7:0] shCtl;
	logic [7:0] next_shDiv;
	logic [7:0] next_shCtl;
	logic       wr;
	logic       rd;
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	// shadow copy of the registers, rebuilt from bus writes
	always_comb begin
		next_shDiv = shDiv;
		next_shCtl = shCtl;
		if (wr && paddr == `COCC_ADDR_DIV)
			next_shDiv = pwdata[7:0];
		if (wr && paddr == `COCC_ADDR_CTL)
			next_shCtl = pwdata[7:0];
	end
	always_ff @(posedge clock) begin
		shDiv <= rst ? `COCC_DIV_RESET : next_shDiv;
		shCtl <= rst ? 8'h18 : next_shCtl;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_div_read;
		rd && paddr == `COCC_ADDR_DIV |-> prdata == {24'h0, shDiv};
	endproperty
	a_div_read: assert property (p_div_read)
		else $error("divider readback");
	property p_ctl_read;
		rd && paddr == `COCC_ADDR_CTL |-> prdata == {24'h0, shCtl};
	endproperty
	a_ctl_read: assert property (p_ctl_read)
		else $error("control readback");
	property p_fmt_write;
		wr && paddr == `COCC_ADDR_CTL |=> driverFormat == $past(pwdata[5:4]);
	endproperty
	a_fmt_write: assert property (p_fmt_write)
		else $error("format update");
	property p_diff;
		(driverFormat inside {COCC_FMT_DIFF, COCC_FMT_HCSL})[*3]
			|-> outPOe && outNOe && outP != outN;
	endproperty
	a_diff: assert property (p_diff)
		else $error("differential pins");
	property p_seta;
		(driverFormat == COCC_FMT_CMOS && shCtl[3:2] == 2'h0)[*3] |-> !outPOe;
	endproperty
	a_seta: assert property (p_seta)
		else $error("positive tristate");
	property p_setb;
		(driverFormat == COCC_FMT_CMOS && shCtl[1:0] == 2'h1)[*3]
			|-> outNOe && !outN;
	endproperty
	a_setb: assert property (p_setb)
		else $error("negative low");
	property p_off;
		(driverFormat == COCC_FMT_OFF)[*3]
			|-> !outP && !outPOe && !outN && !outNOe;
	endproperty
	a_off: assert property (p_off)
		else $error("disabled pins");
	property p_bypass;
		(shCtl[7:6] == 2'h2 && driverFormat == COCC_FMT_DIFF && refPriClk)[*8]
			|-> outP;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("reference level");
endmodule
bind cocc_channel cocc_channel_properties i_chk (.clock(clock), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .refPriClk(refPriClk),
	.outP(outP), .outPOe(outPOe), .outN(outN), .outNOe(outNOe),
	.driverFormat(driverFormat));
`default_nettype wire

/* File: bench/cocc_channel_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cocc_defines.svh"
module cocc_channel_tb_top;
	import cocc_pkg::*;
	logic        clock = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        outP;
	logic        outPOe;
	logic        outN;
	logic        outNOe;
	logic        prv = 0;
	logic        s1 = 0;
	logic        s2 = 0;
	logic        rp = 0;
	logic        rs = 0;
	cocc_fmt_t   driverFormat;
	int          cyc = 0;
	int          failures = 0;
	int          total_checks = 0;
	int          per;
	int          dv[4] = '{0, 1, 2, 255};
	logic [7:0]  cv[3] = '{8'h30, 8'h35, 8'h0f};
	logic [1:0]  oe[3] = '{2'h0, 2'h3, 2'h0};
	cocc_channel i_cocc_channel (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.synthOneClk(s1), .synthTwoClk(s2), .refPriClk(rp), .refSecClk(rs),
		.outP(outP), .outPOe(outPOe), .outN(outN), .outNOe(outNOe),
		.driverFormat(driverFormat));
	always #12.5 clock = ~clock;
	// source periods 16, 20, 24 and 28 clocks, slow enough for the sampler
	always @(posedge clock) begin
		cyc <= cyc + 1;
		prv <= outP;
		if (cyc % 8 == 7) s1 <= ~s1;
		if (cyc % 10 == 9) s2 <= ~s2;
		if (cyc % 12 == 11) rp <= ~rp;
		if (cyc % 14 == 13) rs <= ~rs;
		if (cyc == 60000) begin
			failures = failures + 1;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		// no local limit: only the cycle ceiling ends a stuck access
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// gap from the second to the third rise, so stale divider state has flushed out
	task meas(input string s, input int e);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge clock);
				n++;
			end while (!(outP === 1'b1 && prv === 1'b0) && n < 9000);
		end
		chk(s, e, n);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rst <= 0;
		apb(0, `COCC_ADDR_DIV, 0);
		chk("div reset", 32'h2, rd);
		apb(0, `COCC_ADDR_CTL, 0);
		chk("ctl reset", 32'h18, rd);
		chk("format", COCC_FMT_DIFF, driverFormat);
		apb(0, 12'h0a0, 0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		apb(1, 12'h0a0, 32'hff);
		chk("unmapped write error", 32'h1, {31'h0, err});
		apb(0, `COCC_ADDR_DIV, 0);
		chk("div after stray write", 32'h2, rd);
		$display("reset test done");
		foreach (dv[i]) begin
			apb(1, `COCC_ADDR_DIV, dv[i]);
			meas("synth one period", (dv[i] + 1) * 16);
		end
		apb(0, `COCC_ADDR_DIV, 0);
		chk("div rw", 32'hff, rd);
		apb(1, `COCC_ADDR_DIV, 1);
		apb(1, `COCC_ADDR_CTL, 32'h58);
		meas("synth two period", 40);
		apb(1, `COCC_ADDR_CTL, 32'h98);
		meas("primary period", 24);
		apb(1, `COCC_ADDR_CTL, 32'hd8);
		meas("secondary period", 28);
		$display("divider test done");
		foreach (cv[i]) begin
			apb(1, `COCC_ADDR_CTL, cv[i]);
			repeat (8) @(posedge clock);
			chk("format", cv[i][5:4], driverFormat);
			chk("enables", oe[i], {outPOe, outNOe});
			if (i > 0)
				chk("levels", 0, {outP, outN});
		end
		apb(1, `COCC_ADDR_CTL, 32'h3e);
		repeat (8) @(posedge clock);
		chk("polarity", 3'h7, {outPOe, outNOe, outP ^ outN});
		apb(1, `COCC_ADDR_CTL, 32'h3b);
		repeat (8) @(posedge clock);
		chk("swapped polarity", 3'h7, {outPOe, outNOe, outP ^ outN});
		apb(1, `COCC_ADDR_CTL, 32'h20);
		repeat (8) @(posedge clock);
		chk("hcsl format", COCC_FMT_HCSL, driverFormat);
		chk("hcsl pins", 3'h7, {outPOe, outNOe, outP ^ outN});
		$display("driver test done");
		end_of_test();
	end
endmodule
`default_nettype wire
